// ===== src/swr_pkg.sv
// Package for the sleep, wake, reset-cause and watchdog block.
// Assumes a Wishbone classic slave with byte-wide registers in the low lane.
package swr_pkg;
  // Register byte addresses (all printed offsets sit in the low address byte)
  localparam logic [7:0] SWR_ADDR_POWER_CONTROL = 8'h87;
  localparam logic [7:0] SWR_ADDR_WAKE_ENABLE   = 8'hA9;
  localparam logic [7:0] SWR_ADDR_SCRATCH       = 8'hFE;
  localparam logic [7:0] SWR_ADDR_WDOG_COUNTER  = 8'hFF;
  // Own registers
  localparam logic [7:0] SWR_ADDR_SAFE_KEY      = 8'hA1;
  localparam logic [7:0] SWR_ADDR_GLOBAL_CFG    = 8'hB1;
  localparam logic [7:0] SWR_ADDR_CLOCK_STATUS  = 8'hB9;

  // Reset values
  localparam logic [7:0] SWR_RST_POWER_CONTROL = 8'h10;
  localparam logic [7:0] SWR_RST_BYTE          = 8'h00;

  // Power control fields
  localparam int SWR_PC_BAUD   = 7;
  localparam int SWR_PC_CAUSE_H = 5;
  localparam int SWR_PC_CAUSE_L = 4;
  localparam int SWR_PC_FLAG1  = 3;
  localparam int SWR_PC_FLAG0  = 2;
  localparam int SWR_PC_SLEEP  = 1;
  localparam logic [7:0] SWR_PC_RW_MASK = 8'h8E;

  // Wake-source enable bit positions
  localparam int SWR_WK_USB   = 7;
  localparam int SWR_WK_RX1   = 6;
  localparam int SWR_WK_P15   = 5;
  localparam int SWR_WK_P14   = 4;
  localparam int SWR_WK_P13   = 3;
  localparam int SWR_WK_RST   = 2;
  localparam int SWR_WK_P3X   = 1;
  localparam int SWR_WK_RX0   = 0;

  // Global configuration fields
  localparam int SWR_GC_SWRST = 2;
  localparam int SWR_GC_BOOT  = 1;
  localparam int SWR_GC_WDEN  = 0;

  // Timeout flag position in the clock status register
  localparam int SWR_CS_TIMEOUT = 5;

  // Safe mode keys
  localparam logic [7:0] SWR_KEY_FIRST  = 8'h55;
  localparam logic [7:0] SWR_KEY_SECOND = 8'hAA;

  // Reset cause codes
  localparam logic [1:0] SWR_CAUSE_SW  = 2'h0;
  localparam logic [1:0] SWR_CAUSE_POR = 2'h1;
  localparam logic [1:0] SWR_CAUSE_WD  = 2'h2;
  localparam logic [1:0] SWR_CAUSE_EXT = 2'h3;

  // Timing
  localparam int SWR_CLK_HZ      = 40_000_000;
  localparam int SWR_WDOG_DIV    = 65536;
  localparam int SWR_RELEASE_US  = 100;
  localparam int SWR_POR_US      = 10000;
  localparam int SWR_RSTPIN_NS   = 100;
  localparam int SWR_RELEASE_CYC = SWR_RELEASE_US * (SWR_CLK_HZ / 1_000_000);
  localparam int SWR_POR_CYC     = SWR_POR_US * (SWR_CLK_HZ / 1_000_000);
  localparam int SWR_RSTPIN_CYC  =
    (SWR_RSTPIN_NS * (SWR_CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int SWR_SAFE_WIN    = 64;

  typedef enum logic [1:0] {
    SWR_RUN     = 2'b00,
    SWR_HOLD    = 2'b01,
    SWR_PIN_LOW = 2'b10
  } swr_phase_t;

  // Wake pins in one bundle
  typedef struct packed {
    logic usb_event;
    logic rx1_a;
    logic rx1_b;
    logic rx0_a;
    logic rx0_b;
    logic pin15;
    logic pin14;
    logic pin13;
    logic pin32;
    logic pin33;
  } swr_pins_t;
endpackage

// ===== src/swr_divider.sv
// Divider that emits a one-cycle enable every DIV clocks.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/100ps
module swr_divider #(
  parameter int DIV = 65536
) (
  input  wire logic clk_i,   // System clock
  input  wire logic rst_i,   // Synchronous reset
  output logic      tick_o   // One-cycle enable
);
  localparam int W = $clog2(DIV);
  localparam logic [W-1:0] LAST = W'(DIV - 1);

  logic [W-1:0] cnt_q;

  // Free running count, restarted by reset
  always_ff @(posedge clk_i) begin
    if (rst_i || cnt_q == LAST) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_q + W'(1);
    end
  end

  assign tick_o = (cnt_q == LAST);
endmodule

// ===== src/swr_top.sv
// Sleep, wake, reset-cause and watchdog logic with a Wishbone slave.
// Assumes the core asserts isr_enter_i when entering the watchdog handler.
// Behaviour
// [RULE1] Byte watchdog counter wraps and sets flag
// [RULE2] Counter advances once per 65536 clocks
// [RULE3] Counter write or handler entry clears flag
// [RULE4] Wrap with enable gives held watchdog reset
// [RULE5] Written start value sets timeout period
// [RULE6] Software reloads counter before it wraps
// [RULE7] Scratch byte cleared only by power-on
// [RULE8] Wake enables writable only in safe mode
// [RULE9] Wake bits for USB and UART receive
// [RULE10] Wake bits for port pins and reset
// [RULE11] UART wake follows selected receive pin
// [RULE12] Sleep bit set sleeps, cleared on wake
// [RULE13] Power control bit seven doubles baud
// [RULE14] Free flags, reserved zero, reset 10h
// [RULE15] Bits five four report last reset cause
// [RULE16] Power-on reset held, reloads, clears scratch
// [RULE17] Long reset pin high resets, then held
// [RULE18] Software reset bit resets, self clears
// [RULE19] Software cause recorded unless boot without dog
// [RULE20] Software reset in boot clears boot state
// [RULE21] Keys 55h then AAh open safe mode
// [RULE22] Timeout flag at bit five, read only
// [RULE23] Wake on first enabled qualifying condition
`timescale 1ns/100ps
module swr_top
  import swr_pkg::*;
#(
  parameter int RELEASE_CYC = swr_pkg::SWR_RELEASE_CYC,
  parameter int POR_CYC     = swr_pkg::SWR_POR_CYC,
  parameter int WDOG_DIV    = swr_pkg::SWR_WDOG_DIV
) (
  input  wire logic        clk_i,         // System clock
  input  wire logic        rst_i,         // Synchronous reset
  input  wire logic        wb_cyc_i,      // Wishbone cycle
  input  wire logic        wb_stb_i,      // Wishbone strobe
  input  wire logic        wb_we_i,       // Wishbone write
  input  wire logic [7:0]  wb_adr_i,      // Byte address
  input  wire logic [3:0]  wb_sel_i,      // Byte selects
  input  wire logic [31:0] wb_dat_i,      // Write data
  output logic [31:0]      wb_dat_o,      // Read data
  output logic             wb_ack_o,      // Acknowledge
  input  wire logic        supply_low_i,  // Supply below detect level
  input  wire logic        reset_pin_i,   // Reset pin level
  input  wire logic        ext_rst_en_i,  // External reset enable
  input  wire logic        isr_enter_i,   // Entering watchdog handler
  input  wire logic        rx0_sel_i,     // primary_uart_pin_select
  input  wire logic        rx1_sel_i,     // secondary_uart_pin_select
  input  wire swr_pins_t   pins_i,        // Wake pins
  output logic             core_reset_o,  // Core held in reset
  output logic             config_load_o, // Reload configuration
  output logic             sleeping_o,    // Clock gated, asleep
  output logic             uart_baud_double_o, // Fast baud select
  output logic             wake_o         // Wake pulse
);
  localparam int CW = $clog2(POR_CYC + 1);
  localparam int PW = $clog2(SWR_RSTPIN_CYC + 2);

  typedef struct packed {
    logic [7:0]  power_control;
    logic [7:0]  wake_en;
    logic [7:0]  scratch;
    logic [7:0]  wdog;
    logic        timeout;
    logic        boot;
    logic        wden;
    logic        safe;
    logic        key1;
    logic [6:0]  safe_cnt;
    swr_phase_t  phase;
    logic        por;
    logic [CW-1:0] hold;
    logic [PW-1:0] pin_cnt;
    logic        pin32_q;
    logic        ack;
    logic [31:0] rdat;
  } swr_state_t;

  swr_state_t s_q, s_d;
  logic tick;
  logic wr, rd_req, wr_b0, pin_reset, wake_hit, sw_rst, wrap;
  logic [7:0] wdata, rsel, wake_cond;

  swr_divider #(.DIV(WDOG_DIV)) u_div (
    .clk_i  (clk_i),
    .rst_i  (rst_i || core_reset_o),
    .tick_o (tick)                          // [RULE2]
  );

  // Bus decode: one wait state, ack drops after one cycle
  assign rd_req = wb_cyc_i && wb_stb_i && !s_q.ack;
  assign wr     = rd_req && wb_we_i;
  assign wr_b0  = wr && wb_sel_i[0];
  assign wdata  = wb_dat_i[7:0];

  // Wake conditions, one per enable bit
  always_comb begin
    wake_cond = '0;
    wake_cond[SWR_WK_USB] = pins_i.usb_event;
    wake_cond[SWR_WK_RX1] = !(rx1_sel_i ? pins_i.rx1_b : pins_i.rx1_a); // [RULE11]
    wake_cond[SWR_WK_P15] = !pins_i.pin15;
    wake_cond[SWR_WK_P14] = !pins_i.pin14;
    wake_cond[SWR_WK_P13] = !pins_i.pin13;
    wake_cond[SWR_WK_RST] = reset_pin_i;
    wake_cond[SWR_WK_P3X] = (pins_i.pin32 != s_q.pin32_q) || !pins_i.pin33;
    wake_cond[SWR_WK_RX0] = !(rx0_sel_i ? pins_i.rx0_b : pins_i.rx0_a);
  end

  assign wake_hit  = s_q.power_control[SWR_PC_SLEEP] &&
                     |(wake_cond & s_q.wake_en); // [RULE9] [RULE10] [RULE23]
  assign wrap      = tick && (s_q.wdog == 8'hFF); // [RULE1]
  assign pin_reset = s_q.pin_cnt > PW'(SWR_RSTPIN_CYC);
  assign sw_rst    = wr_b0 && wb_adr_i == SWR_ADDR_GLOBAL_CFG &&
                     wdata[SWR_GC_SWRST];

  // Read multiplexer
  always_comb begin
    rsel = '0;
    unique case (wb_adr_i)
      SWR_ADDR_POWER_CONTROL: rsel = s_q.power_control;
      SWR_ADDR_WAKE_ENABLE:   rsel = s_q.wake_en;
      SWR_ADDR_SCRATCH:       rsel = s_q.scratch;
      SWR_ADDR_WDOG_COUNTER:  rsel = s_q.wdog;
      SWR_ADDR_SAFE_KEY:      rsel = {7'h00, s_q.safe};
      SWR_ADDR_GLOBAL_CFG:    rsel = {6'h00, s_q.boot, s_q.wden};
      SWR_ADDR_CLOCK_STATUS:  begin
        rsel = '0;
        rsel[SWR_CS_TIMEOUT] = s_q.timeout; // [RULE22]
      end
      default:                rsel = '0;
    endcase
  end

  // Next state
  always_comb begin
    s_d = s_q;
    s_d.ack = rd_req;
    s_d.rdat = rd_req ? {24'h000000, rsel} : 32'h00000000;
    s_d.pin32_q = pins_i.pin32;

    // Reset pin high-time counter, saturating
    if (!ext_rst_en_i || !reset_pin_i) begin
      s_d.pin_cnt = '0;
    end else if (!pin_reset) begin
      s_d.pin_cnt = s_q.pin_cnt + PW'(1);
    end

    // Safe mode window and keys
    if (s_q.safe) begin
      s_d.safe_cnt = s_q.safe_cnt - 7'h01;
      if (s_q.safe_cnt == 7'h00) begin
        s_d.safe = 1'b0;
      end
    end
    if (wr_b0 && wb_adr_i == SWR_ADDR_SAFE_KEY) begin
      s_d.key1 = (wdata == SWR_KEY_FIRST);
      s_d.safe = s_q.key1 && (wdata == SWR_KEY_SECOND); // [RULE21]
      s_d.safe_cnt = 7'(SWR_SAFE_WIN - 1);
    end

    unique case (s_q.phase)
      SWR_RUN: begin
        // Watchdog count; a software write wins over the tick
        if (tick) begin
          s_d.wdog = s_q.wdog + 8'h01; // [RULE1] [RULE5]
        end
        if (wrap) begin
          s_d.timeout = 1'b1;
        end else if (isr_enter_i) begin
          s_d.timeout = 1'b0; // [RULE3]
        end
        if (wake_hit) begin
          s_d.power_control[SWR_PC_SLEEP] = 1'b0; // [RULE12]
        end
        if (wr_b0) begin
          unique case (wb_adr_i)
            SWR_ADDR_POWER_CONTROL: begin
              s_d.power_control = (s_q.power_control & ~SWR_PC_RW_MASK) |
                         (wdata & SWR_PC_RW_MASK); // [RULE13] [RULE14]
            end
            SWR_ADDR_WAKE_ENABLE: begin
              if (s_q.safe) begin
                s_d.wake_en = wdata; // [RULE8]
              end
            end
            SWR_ADDR_SCRATCH: s_d.scratch = wdata;
            SWR_ADDR_WDOG_COUNTER: begin
              s_d.wdog = wdata;
              s_d.timeout = wrap; // [RULE3]
            end
            SWR_ADDR_GLOBAL_CFG: begin
              if (s_q.safe) begin
                s_d.boot = wdata[SWR_GC_BOOT];
                s_d.wden = wdata[SWR_GC_WDEN];
              end
            end
            default: ;
          endcase
        end
        // Reset sources, pin first, then watchdog, then software
        if (pin_reset) begin
          s_d.power_control[SWR_PC_CAUSE_H:SWR_PC_CAUSE_L] = SWR_CAUSE_EXT;
          s_d.phase = SWR_PIN_LOW; // [RULE17]
        end else if (wrap && s_q.wden) begin
          s_d.power_control[SWR_PC_CAUSE_H:SWR_PC_CAUSE_L] = SWR_CAUSE_WD; // [RULE4]
          s_d.phase = SWR_HOLD;
          s_d.hold = CW'(RELEASE_CYC - 1);
        end else if (sw_rst) begin
          if (!s_q.boot || s_q.wden) begin
            s_d.power_control[SWR_PC_CAUSE_H:SWR_PC_CAUSE_L] = SWR_CAUSE_SW; // [RULE19]
          end
          s_d.boot = 1'b0; // [RULE20]
          s_d.phase = SWR_HOLD; // [RULE18]
          s_d.hold = CW'(RELEASE_CYC - 1);
        end
        if (s_d.phase != SWR_RUN) begin
          // Warm reset clears everything except cause, scratch and boot state
          s_d.power_control = (SWR_RST_POWER_CONTROL & ~8'h30) |
                     (s_d.power_control & 8'h30);
          s_d.wake_en = SWR_RST_BYTE;
          s_d.wdog = SWR_RST_BYTE;
          s_d.timeout = 1'b0;
          s_d.wden = 1'b0;
          s_d.safe = 1'b0;
          s_d.key1 = 1'b0;
        end
      end
      SWR_PIN_LOW: begin
        // Release delay starts only after the pin falls
        if (!reset_pin_i) begin
          s_d.phase = SWR_HOLD; // [RULE17]
          s_d.hold = CW'(RELEASE_CYC - 1);
        end
      end
      SWR_HOLD: begin
        if (s_q.hold == '0) begin
          s_d.phase = SWR_RUN;
          s_d.por = 1'b0;
        end else begin
          s_d.hold = s_q.hold - CW'(1);
        end
      end
      default: s_d.phase = SWR_RUN;
    endcase

    // Power-on reset overrides all, restarts its own long hold
    if (supply_low_i) begin
      s_d = '0;
      s_d.power_control = SWR_RST_POWER_CONTROL; // [RULE15] [RULE16]
      s_d.scratch = SWR_RST_BYTE; // [RULE7]
      // Edge detector follows the pin so recovery shows no false edge
      s_d.pin32_q = pins_i.pin32;
      // Bus still answers while the supply is low; data reads as zero
      s_d.ack = rd_req;
      s_d.boot = 1'b1;
      s_d.por = 1'b1;
      s_d.phase = SWR_HOLD;
      s_d.hold = CW'(POR_CYC - 1);
    end
  end

  // State register; rst_i acts like a power-on event
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_q <= '0;
      s_q.power_control <= SWR_RST_POWER_CONTROL;
      s_q.boot <= 1'b1;
      s_q.por <= 1'b1;
      s_q.phase <= SWR_HOLD;
      s_q.hold <= CW'(POR_CYC - 1);
      // Idle level of the pin, so no edge is seen after reset
      s_q.pin32_q <= pins_i.pin32;
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs
  assign wb_ack_o           = s_q.ack;
  assign wb_dat_o           = s_q.rdat;
  assign core_reset_o       = (s_q.phase != SWR_RUN);
  assign config_load_o      = s_q.por;
  assign sleeping_o         = s_q.power_control[SWR_PC_SLEEP];
  assign uart_baud_double_o = s_q.power_control[SWR_PC_BAUD];
  assign wake_o             = wake_hit && (s_q.phase == SWR_RUN);
endmodule

// ===== tb/swr_props.sv
// Checker for the sleep, wake, reset-cause and watchdog block.
// Assumes it is bound to swr_top and sees only that module's ports.
`timescale 1ns/100ps
module swr_props
  import swr_pkg::*;
#(
  parameter int RELEASE_CYC = swr_pkg::SWR_RELEASE_CYC,
  parameter int POR_CYC     = swr_pkg::SWR_POR_CYC,
  parameter int WDOG_DIV    = swr_pkg::SWR_WDOG_DIV
) (
  input wire logic        clk_i,              // System clock
  input wire logic        rst_i,              // Synchronous reset
  input wire logic        wb_cyc_i,           // Wishbone cycle
  input wire logic        wb_stb_i,           // Wishbone strobe
  input wire logic        wb_we_i,            // Wishbone write
  input wire logic [7:0]  wb_adr_i,           // Byte address
  input wire logic [3:0]  wb_sel_i,           // Byte selects
  input wire logic [31:0] wb_dat_i,           // Write data
  input wire logic [31:0] wb_dat_o,           // Read data
  input wire logic        wb_ack_o,           // Acknowledge
  input wire logic        reset_pin_i,        // Reset pin level
  input wire logic        ext_rst_en_i,       // External reset enable
  input wire logic        core_reset_o,       // Core held in reset
  input wire logic        config_load_o,      // Reload configuration
  input wire logic        sleeping_o,         // Asleep
  input wire logic        uart_baud_double_o, // Fast baud select
  input wire logic        wake_o              // Wake pulse
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // Request not yet answered; a write to power control outside any hold
  sequence s_take;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_pc_write;
    s_take ##0 (wb_we_i && wb_sel_i[0] && !core_reset_o &&
                wb_adr_i == SWR_ADDR_POWER_CONTROL);
  endsequence
  // Pin held high long enough with the enable set
  sequence s_pin_long;
    (ext_rst_en_i && reset_pin_i) [*6];
  endsequence

  AST_ACK_NEXT: assert property (s_take |=> wb_ack_o)
    else $error("ack did not follow request");
  AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  AST_DAT_IDLE: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("read data outside ack");
  AST_PC_RESERVED: assert property (
    wb_ack_o && !wb_we_i && wb_adr_i == SWR_ADDR_POWER_CONTROL
    |-> !wb_dat_o[6] && !wb_dat_o[0]) else $error("reserved bit set");
  AST_BAUD_WRITE: assert property (
    s_pc_write |=> uart_baud_double_o == wb_dat_i[7])
    else $error("baud bit not written");
  AST_WAKE_CLEARS: assert property (wake_o |=> !sleeping_o)
    else $error("sleep bit kept after wake");
  AST_WAKE_ASLEEP: assert property (wake_o |-> sleeping_o)
    else $error("wake while awake");
  AST_POR_HOLD: assert property (
    $fell(rst_i) |=> (core_reset_o && config_load_o) [*8])
    else $error("power-on hold short");
  AST_CFG_IN_RESET: assert property (
    config_load_o |-> core_reset_o)
    else $error("config load outside reset");
  AST_PIN_RESET: assert property (s_pin_long |=> core_reset_o)
    else $error("long pin high gave no reset");
endmodule

bind swr_top swr_props #(
  .RELEASE_CYC(RELEASE_CYC), .POR_CYC(POR_CYC), .WDOG_DIV(WDOG_DIV)
) u_props (
  .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
  .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .reset_pin_i(reset_pin_i), .ext_rst_en_i(ext_rst_en_i),
  .core_reset_o(core_reset_o), .config_load_o(config_load_o),
  .sleeping_o(sleeping_o), .uart_baud_double_o(uart_baud_double_o),
  .wake_o(wake_o)
);

// ===== tb/swr_top_test.sv
// Self-checking bench for the sleep, wake, reset-cause and watchdog block.
// Assumes shortened hold and divider counts so the run stays brief.
`timescale 1ns/100ps
module swr_top_test;
  import swr_pkg::*;
  localparam int DIV = 16;
  logic        clk_i, rst_i, cyc, stb, we, ack, supply_low, reset_pin;
  logic        ext_en, isr, rx0_sel, rx1_sel, core_rst, cfg_load;
  logic        sleeping, baud, wake;
  logic [7:0]  adr, q, d;
  logic [31:0] wdat, rdat;
  logic [3:0]  sel;
  swr_pins_t   pins;
  int          miscompares, n_tests;

  swr_top #(.RELEASE_CYC(20), .POR_CYC(40), .WDOG_DIV(DIV)) dut (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .supply_low_i(supply_low),
    .reset_pin_i(reset_pin), .ext_rst_en_i(ext_en), .isr_enter_i(isr),
    .rx0_sel_i(rx0_sel), .rx1_sel_i(rx1_sel), .pins_i(pins),
    .core_reset_o(core_rst), .config_load_o(cfg_load),
    .sleeping_o(sleeping), .uart_baud_double_o(baud), .wake_o(wake)
  );

  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end

  // Expected power control read: writable bits plus the cause code
  function automatic logic [7:0] pc_exp(logic [7:0] v, logic [1:0] c);
    return (v & 8'h8E) | {2'b00, c, 4'h0};
  endfunction

  task automatic chk(input string nm, input logic [7:0] got, exp);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // Classic cycle: hold everything until ack is sampled, then release
  task automatic wb(input logic w, input logic [7:0] a, dv);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= a;
    wdat <= {24'h0, dv};
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 50);
    if (ack !== 1'b1) miscompares++;
    q = rdat[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask

  task automatic safe();
    wb(1'b1, SWR_ADDR_SAFE_KEY, SWR_KEY_FIRST);
    wb(1'b1, SWR_ADDR_SAFE_KEY, SWR_KEY_SECOND);
  endtask

  // Waits for a reset hold to start and then to end, both bounded
  task automatic wait_rst();
    int n;
    for (n = 0; n < 400 && core_rst !== 1'b1; n++) @(posedge clk_i);
    chk("reset_seen", core_rst, 1'b1);
    for (n = 0; n < 400 && core_rst !== 1'b0; n++) @(posedge clk_i);
    chk("reset_done", core_rst, 1'b0);
    repeat (2) @(posedge clk_i);
  endtask

  // Drives wake source i active or idle; UART sources follow the select
  task automatic cond(input int i, input logic on);
    case (i)
      7: pins.usb_event <= on;
      6: begin
        pins.rx1_b <= rx1_sel ? !on : 1'b1;
        pins.rx1_a <= rx1_sel ? 1'b1 : !on;
      end
      5: pins.pin15 <= !on;
      4: pins.pin14 <= !on;
      3: pins.pin13 <= !on;
      2: reset_pin <= on;
      1: pins.pin33 <= !on;
      default: begin
        pins.rx0_b <= rx0_sel ? !on : 1'b1;
        pins.rx0_a <= rx0_sel ? 1'b1 : !on;
      end
    endcase
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // Whole run needs little more than a thousand cycles; this limit leaves wide margin
  initial begin
    repeat (30000) @(posedge clk_i);
    miscompares++;
    wrap_up();
  end

  initial begin
    void'($urandom(19754));
    {cyc, stb, we, supply_low, reset_pin, ext_en, isr} = '0;
    {rx0_sel, rx1_sel, adr, wdat} = '0;
    sel = 4'h1;
    pins = '1;
    pins.usb_event = 1'b0;
    rst_i = 1'b1;
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    wait_rst();
    wb(1'b0, SWR_ADDR_POWER_CONTROL, 8'h00);
    chk("pc_reset", q, 8'h10);
    wb(1'b0, SWR_ADDR_SCRATCH, 8'h00);
    chk("keep_reset", q, 8'h00);
    wb(1'b0, 8'h20, 8'h00);
    chk("unmapped", q, 8'h00);
    $display("test reset values done");
    // Random power control writes; wake sources are all off here
    repeat (4) begin
      d = 8'($urandom);
      wb(1'b1, SWR_ADDR_POWER_CONTROL, d);
      wb(1'b0, SWR_ADDR_POWER_CONTROL, 8'h00);
      chk("pc_rw", q, pc_exp(d, SWR_CAUSE_POR));
      chk("baud", baud, d[7]);
      chk("sleep", sleeping, d[1]);
    end
    $display("test power control done");
    wb(1'b1, SWR_ADDR_WAKE_ENABLE, 8'hFF);
    wb(1'b0, SWR_ADDR_WAKE_ENABLE, 8'h00);
    chk("wake_locked", q, 8'h00);
    // Each source alone: a disabled neighbour must not wake, it must
    for (int i = 0; i < 8; i++) begin
      rx0_sel <= 1'($urandom);
      rx1_sel <= 1'($urandom);
      safe();
      wb(1'b1, SWR_ADDR_WAKE_ENABLE, 8'h01 << i);
      wb(1'b0, SWR_ADDR_WAKE_ENABLE, 8'h00);
      chk("wake_en", q, 8'h01 << i);
      wb(1'b1, SWR_ADDR_POWER_CONTROL, 8'h02);
      cond((i + 1) % 8, 1'b1);
      repeat (3) @(posedge clk_i);
      chk("sleep_held", sleeping, 1'b1);
      cond(i, 1'b1);
      repeat (3) @(posedge clk_i);
      chk("woken", sleeping, 1'b0);
      cond(i, 1'b0);
      cond((i + 1) % 8, 1'b0);
    end
    // Edge half of the shared port source: one falling edge must wake
    safe();
    wb(1'b1, SWR_ADDR_WAKE_ENABLE, 8'h02);
    wb(1'b1, SWR_ADDR_POWER_CONTROL, 8'h02);
    pins.pin32 <= 1'b0;
    repeat (3) @(posedge clk_i);
    chk("edge_wake", sleeping, 1'b0);
    $display("test wake sources done");
    wb(1'b1, SWR_ADDR_WDOG_COUNTER, 8'hFE);
    repeat (3 * DIV) @(posedge clk_i);
    wb(1'b0, SWR_ADDR_CLOCK_STATUS, 8'h00);
    chk("flag_set", q & 8'h20, 8'h20);
    wb(1'b0, SWR_ADDR_WDOG_COUNTER, 8'h00);
    chk("wrapped", q == 8'h01 || q == 8'h02, 1'b1);
    // Reload with the flag up: the write itself must clear it
    wb(1'b1, SWR_ADDR_WDOG_COUNTER, 8'h40);
    wb(1'b0, SWR_ADDR_CLOCK_STATUS, 8'h00);
    chk("flag_clear", q & 8'h20, 8'h00);
    repeat (4 * DIV) @(posedge clk_i);
    wb(1'b0, SWR_ADDR_WDOG_COUNTER, 8'h00);
    chk("rate", q == 8'h44 || q == 8'h45, 1'b1);
    // Wrap again, then the handler entry must clear the flag
    wb(1'b1, SWR_ADDR_WDOG_COUNTER, 8'hFE);
    repeat (3 * DIV) @(posedge clk_i);
    isr <= 1'b1;
    @(posedge clk_i);
    isr <= 1'b0;
    wb(1'b0, SWR_ADDR_CLOCK_STATUS, 8'h00);
    chk("isr_clear", q & 8'h20, 8'h00);
    $display("test watchdog count done");
    // Armed watchdog left to wrap; scratch must survive
    d = 8'($urandom);
    wb(1'b1, SWR_ADDR_SCRATCH, d);
    // Lane 0 unselected: the write must be dropped
    sel <= 4'hE;
    wb(1'b1, SWR_ADDR_SCRATCH, ~d);
    sel <= 4'h1;
    wb(1'b0, SWR_ADDR_SCRATCH, 8'h00);
    chk("lane_off", q, d);
    safe();
    wb(1'b1, SWR_ADDR_GLOBAL_CFG, 8'h03);
    // Timely reloads keep the armed dog from wrapping
    repeat (3) begin
      wb(1'b1, SWR_ADDR_WDOG_COUNTER, 8'hF0);
      repeat (8 * DIV) @(posedge clk_i);
      chk("no_wd_reset", core_rst, 1'b0);
    end
    wb(1'b1, SWR_ADDR_WDOG_COUNTER, 8'hFF);
    wait_rst();
    wb(1'b0, SWR_ADDR_POWER_CONTROL, 8'h00);
    chk("cause_wd", q, pc_exp(8'h00, SWR_CAUSE_WD));
    wb(1'b0, SWR_ADDR_SCRATCH, 8'h00);
    chk("keep_wd", q, d);
    ext_en <= 1'b1;
    reset_pin <= 1'b1;
    repeat (8) @(posedge clk_i);
    reset_pin <= 1'b0;
    wait_rst();
    ext_en <= 1'b0;
    wb(1'b0, SWR_ADDR_POWER_CONTROL, 8'h00);
    chk("cause_pin", q, pc_exp(8'h00, SWR_CAUSE_EXT));
    wb(1'b0, SWR_ADDR_SCRATCH, 8'h00);
    chk("keep_pin", q, d);
    $display("test warm resets done");
    // Boot state set and dog off: cause kept, boot state dropped
    safe();
    wb(1'b1, SWR_ADDR_GLOBAL_CFG, 8'h06);
    wait_rst();
    wb(1'b0, SWR_ADDR_POWER_CONTROL, 8'h00);
    chk("cause_kept", q, pc_exp(8'h00, SWR_CAUSE_EXT));
    wb(1'b0, SWR_ADDR_GLOBAL_CFG, 8'h00);
    chk("cfg_clear", q & 8'h06, 8'h00);
    safe();
    wb(1'b1, SWR_ADDR_GLOBAL_CFG, 8'h04);
    wait_rst();
    wb(1'b0, SWR_ADDR_POWER_CONTROL, 8'h00);
    chk("cause_sw", q, pc_exp(8'h00, SWR_CAUSE_SW));
    $display("test software reset done");
    supply_low <= 1'b1;
    repeat (3) @(posedge clk_i);
    chk("cfg_load", cfg_load, 1'b1);
    supply_low <= 1'b0;
    wait_rst();
    wb(1'b0, SWR_ADDR_POWER_CONTROL, 8'h00);
    chk("cause_por", q, 8'h10);
    wb(1'b0, SWR_ADDR_SCRATCH, 8'h00);
    chk("keep_por", q, 8'h00);
    $display("test power-on reset done");
    wrap_up();
  end
endmodule
